// [hdl/cpp_pkg.sv]
package cpp_pkg;
  // ****************************************
  // matrix geometry
  // ****************************************
  localparam int NUM_DEST = 8;
  localparam int NUM_SRC = 16;
  localparam int SEL_W = 4;
  localparam int SLOT_W = 5;
  localparam int ADDR_W = 3;
  // slots fill the low end; the spare slots above them only pass bits through
  localparam int CHAIN_LEN = 80;
  // ****************************************
  // slot layout: enable bit on top, select below
  // ****************************************
  localparam int EN_POS = 4;
  localparam int SEL_LSB = 0;
  // ****************************************
  // reset values
  // ****************************************
  localparam logic [CHAIN_LEN-1:0] CHAIN_RST = '0;
  localparam logic [NUM_DEST-1:0] EN_OFF = '0;
  localparam logic SYNC_LOW = 1'h0;
  localparam logic SYNC_HIGH = 1'h1;
  typedef logic [CHAIN_LEN-1:0] cpp_chain_t;
  typedef logic [SLOT_W-1:0] cpp_slot_t;
endpackage : cpp_pkg

// [hdl/cpp_port.sv]
`timescale 1ns/100ps
`default_nettype none
module cpp_port
  import cpp_pkg::*;
(
  input wire logic I_CLOCK,
  input wire logic I_RST,
  input wire logic I_LINK_CLK,
  input wire logic I_SERIAL_IN,
  input wire logic I_LOAD_MODE_SELECT,
  input wire logic [ADDR_W-1:0] I_OUT_ADDR,
  input wire logic [SEL_W-1:0] I_SRC_SEL,
  input wire logic I_DRIVE_ENABLE_BIT,
  input wire logic I_CHIP_SELECT_N,
  input wire logic I_UPDATE_HOLD,
  input wire logic I_OUT_DISABLE_N,
  output logic O_SERIAL_OUT,
  output logic [NUM_DEST*SEL_W-1:0] O_DEST_SEL,
  output logic [NUM_DEST-1:0] O_DEST_EN
);
  // ****************************************
  // link domain: shift chain
  // ****************************************
  cpp_chain_t chain;
  cpp_chain_t next_chain;
  cpp_chain_t xfer;
  cpp_chain_t next_xfer;
  cpp_slot_t par_word;
  logic req;
  logic next_req;
  logic dirty;
  logic next_dirty;
  logic ack_link;
  logic busy;
  logic load;
  logic ack;

  assign par_word = {I_DRIVE_ENABLE_BIT, I_SRC_SEL};

  always_comb begin
    next_chain = chain;
    load = 1'h0;
    if (!I_CHIP_SELECT_N) begin
      load = 1'h1;
      if (!I_LOAD_MODE_SELECT) begin
        next_chain = {chain[CHAIN_LEN-2:0], I_SERIAL_IN};
      end else begin
        next_chain[SLOT_W*I_OUT_ADDR +: SLOT_W] = par_word;
      end
    end
  end

  // only the system reset clears the chain; the reset pin leaves programming intact
  always_ff @(negedge I_LINK_CLK or posedge I_RST) begin
    if (I_RST) begin
      chain <= CHAIN_RST;
    end else begin
      chain <= next_chain;
    end
  end

  assign O_SERIAL_OUT = chain[CHAIN_LEN-1];

  // ****************************************
  // link to system word crossing
  // ****************************************
  // a load landing while a copy is in flight is marked dirty and resent;
  // that resend needs a further link edge, so a stopped clock can strand it
  assign busy = req != ack_link;

  always_comb begin
    next_xfer = xfer;
    next_req = req;
    next_dirty = dirty;
    if (!busy && (load || dirty)) begin
      next_xfer = next_chain;
      next_req = !req;
      next_dirty = 1'h0;
    end else if (load) begin
      next_dirty = 1'h1;
    end
  end

  always_ff @(negedge I_LINK_CLK or posedge I_RST) begin
    if (I_RST) begin
      xfer <= CHAIN_RST;
      req <= 1'h0;
      dirty <= 1'h0;
    end else begin
      xfer <= next_xfer;
      req <= next_req;
      dirty <= next_dirty;
    end
  end

  cpp_sync #(.RST_VAL(SYNC_LOW)) u_ack_sync (
    .i_clk(~I_LINK_CLK),
    .i_rst(I_RST),
    .i_d(ack),
    .o_q(ack_link)
  );

  // ****************************************
  // system domain: request and pin synchronisers
  // ****************************************
  logic req_sys;
  logic cs_n_sys;
  logic hold_sys;
  logic rst_n_sys;

  cpp_sync #(.RST_VAL(SYNC_LOW)) u_req_sync (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_d(req),
    .o_q(req_sys)
  );

  cpp_sync #(.RST_VAL(SYNC_HIGH)) u_cs_sync (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_d(I_CHIP_SELECT_N),
    .o_q(cs_n_sys)
  );

  cpp_sync #(.RST_VAL(SYNC_HIGH)) u_hold_sync (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_d(I_UPDATE_HOLD),
    .o_q(hold_sys)
  );

  cpp_sync #(.RST_VAL(SYNC_LOW)) u_rst_sync (
    .i_clk(I_CLOCK),
    .i_rst(I_RST),
    .i_d(I_OUT_DISABLE_N),
    .o_q(rst_n_sys)
  );

  // ****************************************
  // system domain: mirror and matrix latches
  // ****************************************
  cpp_chain_t mirror;
  cpp_chain_t next_mirror;
  cpp_chain_t latch;
  cpp_chain_t next_latch;
  logic next_ack;
  logic gate_open;
  logic [NUM_DEST-1:0] latch_en;
  logic [NUM_DEST-1:0] next_en;
  logic out_clr;

  assign gate_open = !hold_sys && !cs_n_sys;

  always_comb begin
    next_mirror = mirror;
    next_ack = ack;
    next_latch = latch;
    if (req_sys != ack) begin
      next_mirror = xfer;
      next_ack = req_sys;
    end
    if (gate_open) begin
      next_latch = mirror;
    end
  end

  always_ff @(posedge I_CLOCK or posedge I_RST) begin
    if (I_RST) begin
      mirror <= CHAIN_RST;
      ack <= 1'h0;
      latch <= CHAIN_RST;
    end else begin
      mirror <= next_mirror;
      ack <= next_ack;
      latch <= next_latch;
    end
  end

  // ****************************************
  // decode slots to destination channels
  // ****************************************
  genvar g;
  generate
    for (g = 0; g < NUM_DEST; g++) begin : g_dest
      assign O_DEST_SEL[g*SEL_W +: SEL_W] = latch[g*SLOT_W+SEL_LSB +: SEL_W];
      assign latch_en[g] = latch[g*SLOT_W+EN_POS];
    end
  endgenerate

  // the pin clears the enables at once; release waits for the synchroniser
  assign out_clr = I_RST || !I_OUT_DISABLE_N;

  always_comb begin
    next_en = rst_n_sys ? latch_en : EN_OFF;
  end

  always_ff @(posedge I_CLOCK or posedge out_clr) begin
    if (out_clr) begin
      O_DEST_EN <= EN_OFF;
    end else begin
      O_DEST_EN <= next_en;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  AST_SHIFT: assert property (@(negedge I_LINK_CLK) disable iff (I_RST)
    (!I_CHIP_SELECT_N && !I_LOAD_MODE_SELECT) |=>
      (chain[0] == $past(I_SERIAL_IN)) && (chain[CHAIN_LEN-1:1] == $past(chain[CHAIN_LEN-2:0])))
    else $error("serial shift wrong");

  AST_SEROUT: assert property (@(negedge I_LINK_CLK) disable iff (I_RST)
    (!I_CHIP_SELECT_N && !I_LOAD_MODE_SELECT) |=> O_SERIAL_OUT == $past(chain[CHAIN_LEN-2]))
    else $error("serial out not chain end");

  AST_LEN: assert property (@(negedge I_LINK_CLK) disable iff (I_RST)
    (!I_CHIP_SELECT_N && !I_LOAD_MODE_SELECT) [*2] |=> O_SERIAL_OUT == $past(chain[CHAIN_LEN-3], 2))
    else $error("chain length wrong");

  AST_PAR: assert property (@(negedge I_LINK_CLK) disable iff (I_RST)
    (!I_CHIP_SELECT_N && I_LOAD_MODE_SELECT) |=>
      chain[SLOT_W*$past(I_OUT_ADDR) +: SLOT_W] == $past(par_word))
    else $error("parallel slot write wrong");

  AST_CS: assert property (@(negedge I_LINK_CLK) disable iff (I_RST)
    I_CHIP_SELECT_N |=> chain == $past(chain))
    else $error("chain changed while deselected");

  AST_HOLD: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    !gate_open |=> $stable(latch))
    else $error("latch moved while held");

  AST_FOLLOW: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    gate_open |=> latch == $past(mirror))
    else $error("latch not transparent");

  AST_RST_OFF: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    !rst_n_sys |-> O_DEST_EN == EN_OFF)
    else $error("outputs enabled in reset");

  AST_RST_KEEP: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (!rst_n_sys && !gate_open) |=> $stable(latch) && ($stable(mirror) || $past(req_sys != ack)))
    else $error("reset disturbed programming");

  AST_EN: assert property (@(posedge I_CLOCK) disable iff (I_RST)
    (rst_n_sys && I_OUT_DISABLE_N) ##1 I_OUT_DISABLE_N |-> O_DEST_EN == $past(latch_en))
    else $error("enable not from slot");

  COV_SER: cover property (@(negedge I_LINK_CLK) !I_CHIP_SELECT_N && !I_LOAD_MODE_SELECT);
  COV_PAR: cover property (@(negedge I_LINK_CLK) !I_CHIP_SELECT_N && I_LOAD_MODE_SELECT);
  COV_UPD: cover property (@(posedge I_CLOCK) gate_open && (latch != mirror));
  COV_RST: cover property (@(posedge I_CLOCK) !rst_n_sys && (latch_en != EN_OFF));
endmodule : cpp_port
`default_nettype wire

// [hdl/cpp_sync.sv]
`timescale 1ns/100ps
`default_nettype none
module cpp_sync
  import cpp_pkg::*;
#(
  parameter logic RST_VAL = 1'h0
) (
  input wire logic i_clk,
  input wire logic i_rst,
  input wire logic i_d,
  output logic o_q
);
  // ****************************************
  // two-stage synchroniser
  // ****************************************
  logic meta;
  logic next_meta;
  logic next_q;

  always_comb begin
    next_meta = i_d;
    next_q = meta;
  end

  always_ff @(posedge i_clk or posedge i_rst) begin
    if (i_rst) begin
      meta <= RST_VAL;
      o_q <= RST_VAL;
    end else begin
      meta <= next_meta;
      o_q <= next_q;
    end
  end
endmodule : cpp_sync
`default_nettype wire

// [verif/cpp_ctrl_model.sv]
`timescale 1ns/100ps
`default_nettype none
// ****
// controller on the programming pins
// ****
module cpp_ctrl_model (
  output logic o_link_clk,
  output logic o_din,
  output logic o_mode,
  output logic [2:0] o_addr,
  output logic [3:0] o_sel,
  output logic o_en,
  output logic o_cs_n
);
  initial begin
    o_link_clk = 1'h1;
    o_din = 1'h0;
    o_mode = 1'h0;
    {o_addr, o_en, o_sel} = 8'h0;
    o_cs_n = 1'h1;
  end
  // link clock idles high, so no stray falling edge outside frames
  task automatic pulse(input logic cs_n, input logic mode, input logic din, input logic [7:0] w);
    o_cs_n = cs_n;
    o_mode = mode;
    o_din = din;
    {o_addr, o_en, o_sel} = w;
    #6 o_link_clk = 1'h0;
    // hold time over: stale data must not look valid
    #3 o_din = ~o_din;
    {o_addr, o_en, o_sel} = ~w;
    #3 o_link_clk = 1'h1;
  endtask : pulse
  task automatic set_cs(input logic v);
    o_cs_n = v;
  endtask : set_cs
endmodule : cpp_ctrl_model
`default_nettype wire

// [verif/test_cpp_port.sv]
`timescale 1ns/100ps
`default_nettype none
module test_cpp_port;
  import cpp_pkg::*;
  logic I_CLOCK, I_RST, hold, dis_n, look;
  wire logic lclk, din, mode, en, cs_n, sout;
  wire logic [2:0] addr;
  wire logic [3:0] sel;
  wire logic [31:0] dsel;
  wire logic [7:0] den;
  logic [4:0] slot [8];
  logic [4:0] lat [8];
  logic hist [$];
  logic [39:0] exp_q [$];
  int num_errors = 0;
  int n_checks = 0;
  cpp_ctrl_model i_cpp_ctrl_model(.o_link_clk(lclk), .o_din(din), .o_mode(mode), .o_addr(addr),
    .o_sel(sel), .o_en(en), .o_cs_n(cs_n));
  cpp_port i_cpp_port(.I_CLOCK(I_CLOCK), .I_RST(I_RST), .I_LINK_CLK(lclk), .I_SERIAL_IN(din),
    .I_LOAD_MODE_SELECT(mode), .I_OUT_ADDR(addr), .I_SRC_SEL(sel), .I_DRIVE_ENABLE_BIT(en),
    .I_CHIP_SELECT_N(cs_n), .I_UPDATE_HOLD(hold), .I_OUT_DISABLE_N(dis_n),
    .O_SERIAL_OUT(sout), .O_DEST_SEL(dsel), .O_DEST_EN(den));
  task automatic check(input logic [39:0] seen, input logic [39:0] want);
    n_checks++;
    if (seen !== want) begin
      num_errors++;
      $display("MISMATCH %0t got %h want %h", $time, seen, want);
    end
  endtask : check
  task automatic summarize();
    if (num_errors == 0 && n_checks > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask : summarize
  task automatic ser_bit(input logic b);
    i_cpp_ctrl_model.pulse(1'h0, 1'h0, b, 8'h0);
    hist.push_back(b);
    if (hist.size() >= CHAIN_LEN) check(40'(sout), 40'(hist[hist.size()-CHAIN_LEN]));
  endtask : ser_bit
  task automatic load_ser();
    // spare slots above the eight real ones go first and only pass through
    repeat (CHAIN_LEN - NUM_DEST * SLOT_W) ser_bit(1'($urandom));
    for (int k = 7; k >= 0; k--) begin
      slot[k] = 5'($urandom);
      for (int b = 4; b >= 0; b--) ser_bit(slot[k][b]);
    end
  endtask : load_ser
  task automatic update(input logic c);
    logic [39:0] e;
    // spare edges with chip select high let the domain copy finish
    repeat (6) begin
      i_cpp_ctrl_model.pulse(1'h1, 1'h0, 1'h0, 8'h0);
      repeat (2) @(negedge I_CLOCK);
    end
    i_cpp_ctrl_model.set_cs(c);
    @(negedge I_CLOCK) hold <= 1'h0;
    repeat (8) @(negedge I_CLOCK);
    hold <= 1'h1;
    repeat (4) @(negedge I_CLOCK);
    for (int k = 0; k < 8; k++) begin
      if (!c) lat[k] = slot[k];
      e[8+4*k +: 4] = lat[k][3:0];
      e[k] = lat[k][4];
    end
    exp_q.push_back(e);
    look <= 1'h1;
    @(negedge I_CLOCK) look <= 1'h0;
    i_cpp_ctrl_model.set_cs(1'h1);
  endtask : update
  always @(posedge I_CLOCK) begin
    if (look) check({dsel, den}, exp_q.pop_front());
  end
  initial begin
    I_CLOCK = 1'h0;
    forever #20 I_CLOCK = ~I_CLOCK;
  end
  initial begin
    #100000 num_errors++;
    summarize();
  end
  initial begin
    I_RST = 1'h1;
    hold = 1'h1;
    dis_n = 1'h1;
    look = 1'h0;
    void'($urandom(32'h6E6597CB));
    repeat (12) @(negedge I_CLOCK);
    I_RST <= 1'h0;
    repeat (3) @(negedge I_CLOCK);
    load_ser();
    load_ser();
    update(1'h0);
    for (int a = 0; a < 8; a++) begin
      slot[a] = 5'($urandom);
      i_cpp_ctrl_model.pulse(1'h0, 1'h1, 1'h0, {3'(a), slot[a]});
    end
    update(1'h1);
    @(negedge I_CLOCK);
    i_cpp_ctrl_model.pulse(1'h1, 1'h1, 1'h0, 8'hFF);
    update(1'h0);
    @(negedge I_CLOCK) dis_n <= 1'h0;
    #1 check(40'(den), 40'h0);
    repeat (3) @(negedge I_CLOCK);
    dis_n <= 1'h1;
    update(1'h1);
    summarize();
  end
endmodule : test_cpp_port
`default_nettype wire
